/* File: design/two_wire_serial_channel.sv */
// Two-wire synchronous serial channel: 8-bit words, MSB first, open-drain data.
// Assumes external pull-ups on clock and data lines; pins sampled by i_clk.
// What this block does
// - Shift write starts only when enabled and ready
// - Write made while disabled never starts later
// - Eight bits shifted: stop, set done flag
// - Actual data line level shifted back in
// - Match flag when slave address equals shift
// - Clock pin static level from port latch when enabled with an internal clock
// - Release/command triggers set data pin level
// - Eight bits MSB first, selectable data pin
// - Disabled channel stays idle, no transfers
// - Shift on falling, capture on rising edge
// - Release trigger sets latch, self clears
// - Command trigger clears latch, self clears
// - Clock select: external, timer two, timer
module two_wire_serial_channel
  import serial_channel_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_channel_enable,
  input  wire logic [1:0] i_clock_select,
  input  wire logic       i_data_pin_select,
  input  wire logic       i_shift_wr,
  input  wire logic [7:0] i_shift_wdata,
  input  wire logic       i_slave_addr_wr,
  input  wire logic [7:0] i_slave_addr_wdata,
  input  wire logic       i_release_trigger_wr,
  input  wire logic       i_command_trigger_wr,
  input  wire logic       i_clock_port_latch_wr,
  input  wire logic       i_clock_port_latch_wdata,
  input  wire logic       i_transfer_done_clear,
  input  wire logic       i_timer_two_output,
  input  wire logic       i_timer_clock,
  input  wire logic       i_serial_clock_pin,
  output logic            o_serial_clock_pin_out,
  output logic            o_serial_clock_pin_oe_n,
  input  wire logic       i_data_bus_pin_a,
  output logic            o_data_bus_pin_a_out,
  output logic            o_data_bus_pin_a_oe_n,
  input  wire logic       i_data_bus_pin_b,
  output logic            o_data_bus_pin_b_out,
  output logic            o_data_bus_pin_b_oe_n,
  output logic [7:0]      o_shift_register,
  output logic            o_transfer_done_flag,
  output logic            o_address_match_flag,
  output logic            o_busy,
  output logic            o_output_latch,
  output logic            o_release_trigger,
  output logic            o_command_trigger,
  output logic            o_clock_port_latch
);

  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  logic              sck_prev_ff;
  logic              tmr_prev_ff;
  xfer_state_type    state_ff;
  logic [3:0]        bit_cnt_ff;
  logic [7:0]        shift_ff;
  logic [7:0]        slave_addr_ff;
  logic              out_latch_ff;
  logic              sck_level_ff;
  logic              port_latch_ff;
  logic              done_ff;
  logic              match_ff;
  logic              release_trigger_ff;
  logic              command_trigger_ff;
  logic              internal_clk;
  logic              tmr_sel;
  logic              tick;
  logic              fall_ev;
  logic              rise_ev;
  logic              data_in;
  logic              start_ok;
  logic              start;
  logic              last_rise;

  // Timer and pin inputs are foreign to i_clk
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync1_ff <= SYNC_RESET;
      sync2_ff <= SYNC_RESET;
    end else begin
      sync1_ff <= {i_timer_clock, i_timer_two_output, i_data_bus_pin_b, i_data_bus_pin_a, i_serial_clock_pin};
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sck_prev_ff <= 1'h1;
      tmr_prev_ff <= 1'h0;
    end else begin
      sck_prev_ff <= sync2_ff[SYNC_SCK];
      tmr_prev_ff <= tmr_sel;
    end
  end

  assign internal_clk = i_clock_select[1];
  assign tmr_sel = (i_clock_select == CLK_SEL_TIMER_CS) ? sync2_ff[SYNC_TMR_CS] : sync2_ff[SYNC_TMR2];
  assign tick = tmr_sel & ~tmr_prev_ff;
  // Internal mode edges come from our own clock level, external from the pin
  assign fall_ev = (state_ff == ST_SHIFT) &&
                   (internal_clk ? (tick && sck_level_ff) : (sck_prev_ff && !sync2_ff[SYNC_SCK]));
  assign rise_ev = (state_ff == ST_SHIFT) &&
                   (internal_clk ? (tick && !sck_level_ff) : (!sck_prev_ff && sync2_ff[SYNC_SCK]));
  assign data_in = i_data_pin_select ? sync2_ff[SYNC_PIN_B] : sync2_ff[SYNC_PIN_A];
  // External clock must be back high before another word
  assign start_ok = i_channel_enable && (state_ff == ST_IDLE) &&
                    (internal_clk || sync2_ff[SYNC_SCK]);
  assign start = i_shift_wr && start_ok;
  assign last_rise = rise_ev && (bit_cnt_ff == LAST_BIT_INDEX);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_ff   <= ST_IDLE;
      bit_cnt_ff <= BIT_COUNT_RESET;
    end else if (!i_channel_enable) begin
      state_ff   <= ST_IDLE;
      bit_cnt_ff <= BIT_COUNT_RESET;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          bit_cnt_ff <= BIT_COUNT_RESET;
          if (start) begin
            state_ff <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (last_rise) begin
            state_ff <= ST_IDLE;
          end
          if (rise_ev) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Write accepted only on a start; a refused write is dropped, not held
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      shift_ff <= SHIFT_RESET;
    end else if (start) begin
      shift_ff <= i_shift_wdata;
    end else if (rise_ev) begin
      shift_ff <= {shift_ff[6:0], data_in};
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sck_level_ff <= 1'h1;
    end else if (!i_channel_enable || !internal_clk || state_ff == ST_IDLE) begin
      sck_level_ff <= 1'h1;
    end else if (tick) begin
      sck_level_ff <= ~sck_level_ff;
    end
  end

  // Triggers live one cycle, then act on the latch and clear
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      release_trigger_ff <= 1'h0;
      command_trigger_ff <= 1'h0;
    end else begin
      release_trigger_ff <= i_channel_enable && i_release_trigger_wr;
      command_trigger_ff <= i_channel_enable && i_command_trigger_wr;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      out_latch_ff <= OUT_LATCH_RESET;
    end else if (start) begin
      out_latch_ff <= i_shift_wdata[WORD_BITS-1];
    end else if (fall_ev) begin
      out_latch_ff <= shift_ff[WORD_BITS-1];
    end else if (release_trigger_ff) begin
      out_latch_ff <= 1'h1;
    end else if (command_trigger_ff) begin
      out_latch_ff <= 1'h0;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      port_latch_ff <= PORT_LATCH_RESET;
    end else if (i_clock_port_latch_wr) begin
      port_latch_ff <= i_clock_port_latch_wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      slave_addr_ff <= SLAVE_ADDR_RESET;
    end else if (i_slave_addr_wr) begin
      slave_addr_ff <= i_slave_addr_wdata;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      done_ff <= 1'h0;
    end else if (last_rise && i_channel_enable) begin
      done_ff <= 1'h1;
    end else if (i_transfer_done_clear) begin
      done_ff <= 1'h0;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      match_ff <= 1'h0;
    end else begin
      match_ff <= i_channel_enable && (slave_addr_ff == shift_ff);
    end
  end

  // Open drain: only ever drive low; the line is a wired AND
  assign o_serial_clock_pin_out  = 1'h0;
  assign o_serial_clock_pin_oe_n = ~(i_channel_enable && internal_clk) | (sck_level_ff & port_latch_ff);
  assign o_data_bus_pin_a_out    = 1'h0;
  assign o_data_bus_pin_a_oe_n   = ~i_channel_enable | i_data_pin_select | out_latch_ff;
  assign o_data_bus_pin_b_out    = 1'h0;
  assign o_data_bus_pin_b_oe_n   = ~i_channel_enable | ~i_data_pin_select | out_latch_ff;
  assign o_shift_register        = shift_ff;
  assign o_transfer_done_flag    = done_ff;
  assign o_address_match_flag    = match_ff;
  assign o_busy                  = (state_ff == ST_SHIFT);
  assign o_output_latch          = out_latch_ff;
  assign o_release_trigger       = release_trigger_ff;
  assign o_command_trigger       = command_trigger_ff;
  assign o_clock_port_latch      = port_latch_ff;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  start_gate_a: assert property ((state_ff == ST_IDLE) && !(i_shift_wr && start_ok) |=> state_ff == ST_IDLE)
    else $error("transfer began without a qualifying write");
  late_enable_a: assert property (!i_channel_enable ##1 i_channel_enable && !i_shift_wr |=> state_ff == ST_IDLE)
    else $error("earlier write started a transfer after enable");
  done_stop_a: assert property (last_rise && i_channel_enable |=> done_ff && state_ff == ST_IDLE)
    else $error("eighth rising edge did not stop and flag");
  readback_a: assert property (rise_ev && i_channel_enable && !start |=> shift_ff[0] == $past(data_in))
    else $error("bus level not shifted back in");
  match_flag_a: assert property (i_channel_enable && slave_addr_ff == shift_ff |=> match_ff)
    else $error("address match flag missing");
  sck_static_a: assert property (i_channel_enable && internal_clk && state_ff == ST_IDLE && sck_level_ff
                                 |-> o_serial_clock_pin_oe_n == port_latch_ff)
    else $error("clock pin does not follow port latch");
  release_a: assert property (i_channel_enable && i_release_trigger_wr && !start
                              ##1 !fall_ev && !start && !i_release_trigger_wr |=> out_latch_ff && !release_trigger_ff)
    else $error("release trigger did not set latch");
  command_a: assert property (i_channel_enable && i_command_trigger_wr && !i_release_trigger_wr && !start
                              ##1 !fall_ev && !start && !i_command_trigger_wr |=> !out_latch_ff && !command_trigger_ff)
    else $error("command trigger did not clear latch");
  stop_idle_a: assert property (!i_channel_enable |=> state_ff == ST_IDLE && !release_trigger_ff && !command_trigger_ff && !match_ff)
    else $error("disabled channel not idle");
  msb_first_a: assert property (start |=> out_latch_ff == $past(i_shift_wdata[7]))
    else $error("first bit is not the MSB");
  pin_drive_a: assert property (i_channel_enable && !i_data_pin_select
                                |-> o_data_bus_pin_a_oe_n == out_latch_ff && o_data_bus_pin_b_oe_n)
    else $error("data pin drive does not follow latch");

  word_cover_c: cover property (start ##[1:400] last_rise);
  external_cover_c: cover property (!internal_clk && last_rise);
  match_cover_c: cover property (done_ff && match_ff);
endmodule : two_wire_serial_channel

/* File: design/serial_channel_pkg.sv */
// Constants and types of the two-wire serial channel.
// Assumes a single system clock; pins and timer outputs arrive asynchronously.
package serial_channel_pkg;
  localparam int          WORD_BITS        = 8;
  localparam logic [3:0]  LAST_BIT_INDEX   = 4'h7;
  localparam logic [3:0]  BIT_COUNT_RESET  = 4'h0;
  localparam logic [7:0]  SHIFT_RESET      = 8'hFF;
  localparam logic [7:0]  SLAVE_ADDR_RESET = 8'h00;
  localparam logic        PORT_LATCH_RESET = 1'h1;
  localparam logic        OUT_LATCH_RESET  = 1'h1;
  localparam logic [1:0]  CLK_SEL_TIMER2   = 2'h2;
  localparam logic [1:0]  CLK_SEL_TIMER_CS = 2'h3;
  localparam int          SYNC_W           = 5;
  localparam int          SYNC_SCK         = 0;
  localparam int          SYNC_PIN_A       = 1;
  localparam int          SYNC_PIN_B       = 2;
  localparam int          SYNC_TMR2        = 3;
  localparam int          SYNC_TMR_CS      = 4;
  localparam logic [4:0]  SYNC_RESET       = 5'h1F;

  typedef enum logic {
    ST_IDLE,
    ST_SHIFT
  } xfer_state_type;
endpackage : serial_channel_pkg

/* File: tb/peer_device.sv */
// Peer device sharing the two-wire bus: open-drain clock and data.
// Assumes the bench resolves both lines as wired-AND with pull-ups.
module peer_device (
  input  wire logic       i_sck_line,
  input  wire logic       i_data_line,
  output logic            o_sck_oe_n,
  output logic            o_data_oe_n,
  output logic [7:0]      o_rx_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tx_ff = 8'hFF;
  logic [2:0] bit_ff = 3'h0;
  initial begin
    o_sck_oe_n = 1'b1;
    o_data_oe_n = 1'b1;
    o_rx_word = 8'h00;
  end
  // Bit count restarts per word; stray line edges before a frame must not skew the late release
  task automatic load(input logic [7:0] word);
    tx_ff = word;
    bit_ff = 3'h0;
  endtask : load
  // Clock runs only inside a frame, released between frames
  task automatic run_frame;
    repeat (8) begin
      #200 o_sck_oe_n = 1'b0;
      #200 o_sck_oe_n = 1'b1;
    end
  endtask : run_frame
  always @(negedge i_sck_line) begin
    o_data_oe_n <= tx_ff[7];
    tx_ff <= {tx_ff[6:0], 1'h1};
  end
  always @(posedge i_sck_line) begin
    o_rx_word <= {o_rx_word[6:0], i_data_line};
    bit_ff <= bit_ff + 3'h1;
    // Late release so the far side still sees the last bit
    if (bit_ff == 3'h7) o_data_oe_n <= #150 1'b1;
  end
endmodule : peer_device

/* File: tb/two_wire_serial_channel_tb.sv */
// Bench for the two-wire serial channel with one peer on data pin a.
// Assumes open-drain pins with pull-ups, resolved here as wired-AND.
module two_wire_serial_channel_tb
  import serial_channel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, i_channel_enable = 1'b0, i_data_pin_select = 1'b0;
  logic [1:0] i_clock_select = 2'h2;
  logic i_shift_wr = 1'b0, i_slave_addr_wr = 1'b0, i_release_trigger_wr = 1'b0, i_command_trigger_wr = 1'b0;
  logic i_clock_port_latch_wr = 1'b0, i_clock_port_latch_wdata = 1'b1, i_transfer_done_clear = 1'b0;
  logic i_timer_two_output = 1'b0, i_timer_clock = 1'b0;
  logic [7:0] i_shift_wdata = 8'h00, i_slave_addr_wdata = 8'h00;
  wire logic i_serial_clock_pin, i_data_bus_pin_a, i_data_bus_pin_b, peer_sck_oe_n, peer_data_oe_n;
  wire logic o_serial_clock_pin_out, o_serial_clock_pin_oe_n, o_data_bus_pin_a_out, o_data_bus_pin_a_oe_n;
  wire logic o_data_bus_pin_b_out, o_data_bus_pin_b_oe_n, o_transfer_done_flag, o_address_match_flag, o_busy;
  wire logic o_output_latch, o_release_trigger, o_command_trigger, o_clock_port_latch;
  wire logic [7:0] o_shift_register, rx_word;
  int bad_count = 0, tests_run = 0;
  assign i_serial_clock_pin = (o_serial_clock_pin_oe_n | o_serial_clock_pin_out) & peer_sck_oe_n;
  assign i_data_bus_pin_a = (o_data_bus_pin_a_oe_n | o_data_bus_pin_a_out) & peer_data_oe_n;
  assign i_data_bus_pin_b = o_data_bus_pin_b_oe_n | o_data_bus_pin_b_out;
  always #25 i_clk = ~i_clk;
  always #200 i_timer_two_output = ~i_timer_two_output;
  always #150 i_timer_clock = ~i_timer_clock;
  two_wire_serial_channel dut (.*);
  peer_device peer (.i_sck_line(i_serial_clock_pin), .i_data_line(i_data_bus_pin_a),
    .o_sck_oe_n(peer_sck_oe_n), .o_data_oe_n(peer_data_oe_n), .o_rx_word(rx_word));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude;
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask : step
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask : pulse
  task automatic set_mode(input logic [1:0] sel);
    i_channel_enable = 1'b0;
    step(1);
    i_clock_select = sel;
    i_channel_enable = 1'b1;
    step(3);
  endtask : set_mode
  // Loads both registers, clears done, starts and waits for done
  task automatic transfer(input logic [7:0] d, input int limit);
    int n;
    n = 0;
    i_slave_addr_wdata = d;
    pulse(i_slave_addr_wr);
    pulse(i_transfer_done_clear);
    i_shift_wdata = d;
    pulse(i_shift_wr);
    check("busy at start", o_busy, 8'h01);
    while (o_transfer_done_flag !== 1'b1 && n < limit) begin
      step(1);
      n++;
    end
    if (n >= limit) begin
      bad_count++;
      $display("ERROR done flag expected 1 seen timeout");
      conclude();
    end
    step(1);
    check("busy after word", o_busy, 8'h00);
  endtask : transfer
  task automatic s_reset;
    check("reset shift", o_shift_register, SHIFT_RESET);
    check("reset flags", {o_busy, o_transfer_done_flag, o_address_match_flag, o_output_latch, o_release_trigger,
      o_command_trigger, o_clock_port_latch, o_data_bus_pin_a_oe_n}, 8'h13);
  endtask : s_reset
  task automatic s_refused;
    i_shift_wdata = 8'h5A;
    pulse(i_shift_wr);
    step(3);
    check("write while stopped", {o_busy, o_serial_clock_pin_oe_n, o_data_bus_pin_a_oe_n}, 8'h03);
    i_channel_enable = 1'b1;
    step(20);
    check("late enable busy", o_busy, 8'h00);
    check("late enable shift", o_shift_register, SHIFT_RESET);
  endtask : s_refused
  task automatic s_transmit;
    transfer(8'hA5, 400);
    check("peer got word", rx_word, 8'hA5);
    check("read back", o_shift_register, 8'hA5);
    check("match ok", o_address_match_flag, 8'h01);
    check("clock rests high", i_serial_clock_pin, 8'h01);
  endtask : s_transmit
  task automatic s_error;
    set_mode(2'h3);
    peer.load(8'h0F);
    transfer(8'hC3, 400);
    check("bus level kept", o_shift_register, 8'h03);
    check("match error", o_address_match_flag, 8'h00);
  endtask : s_error
  task automatic s_receive;
    set_mode(2'h1);
    peer.load(8'h3C);
    pulse(i_transfer_done_clear);
    i_shift_wdata = 8'hFF;
    pulse(i_shift_wr);
    check("external start", o_busy, 8'h01);
    peer.run_frame();
    step(8);
    check("received", o_shift_register, 8'h3C);
    check("done external", {o_transfer_done_flag, o_busy}, 8'h02);
  endtask : s_receive
  task automatic s_triggers;
    set_mode(2'h2);
    i_data_pin_select = 1'b1;
    transfer(8'h69, 400);
    check("pin b read back", o_shift_register, 8'h69);
    check("pin b match", o_address_match_flag, 8'h01);
    pulse(i_command_trigger_wr);
    check("cmd trigger set", o_command_trigger, 8'h01);
    step(1);
    check("cmd effect", {o_command_trigger, o_output_latch, o_data_bus_pin_b_oe_n, o_data_bus_pin_a_oe_n},
      8'h01);
    pulse(i_release_trigger_wr);
    step(1);
    check("rel effect", {o_release_trigger, o_output_latch, o_data_bus_pin_b_oe_n}, 8'h03);
    i_channel_enable = 1'b0;
    pulse(i_command_trigger_wr);
    step(1);
    check("trigger cleared off", {o_command_trigger, o_output_latch}, 8'h01);
    i_data_pin_select = 1'b0;
    i_channel_enable = 1'b1;
    step(2);
  endtask : s_triggers
  task automatic s_port_latch;
    i_clock_port_latch_wdata = 1'b0;
    pulse(i_clock_port_latch_wr);
    step(1);
    check("clock static low", {o_clock_port_latch, i_serial_clock_pin}, 8'h00);
    i_clock_port_latch_wdata = 1'b1;
    pulse(i_clock_port_latch_wr);
    step(1);
    check("clock static high", {o_clock_port_latch, i_serial_clock_pin}, 8'h03);
  endtask : s_port_latch
  initial begin
    step(3);
    i_sys_rst = 1'b0;
    step(2);
    s_reset();
    s_refused();
    s_transmit();
    s_error();
    s_receive();
    s_triggers();
    s_port_latch();
    conclude();
  end
endmodule : two_wire_serial_channel_tb
